// File: usb_cfg_map.vh
// Overview of operation
// RULE_01: Bit 30 enables link power management support
// RULE_02: Bit 29 clear blocks suspend output
// RULE_03: Bits 15:13 pick connect speed, reset 000
// RULE_04: Bit 10 write one resets bulk-in transmitter
// RULE_05: Bit 9 write one resets bulk-out receiver
// RULE_06: Bit 6 picks ZLP or NAK on empty
// RULE_07: Bit 5 lets burst limit constrain bursts
// RULE_08: Read-only bit 4 reports plus/minus pin swap
// RULE_09: Bit 2 gates remote wakeup support
// RULE_10: Bit 1 selects bus or self powered
// RULE_11: Bit 0 clear stalls bulk-out on sync loss
// RULE_12: Protected fields survive the reset protection mechanism
// RULE_13: Suspend default from EEPROM, OTP, else one
// RULE_14: Pin swap default from EEPROM, OTP, else zero
// RULE_15: LPM and wakeup defaults: EEPROM, OTP, else one
// RULE_16: Power source default from EEPROM only, else one
// RULE_17: USB or lite reset restores loaded image values
// RULE_18: Reserved bits read zero, ignore writes
// RULE_19: Self-clearing reset bits return to zero alone
`ifndef USB_CFG_MAP_VH
`define USB_CFG_MAP_VH
`define ADDR_USB_CONFIG_0 12'h080
`define ADDR_W 12
`define BIT_LPM 30
`define BIT_SUSP 29
`define SPD_HI 15
`define SPD_LO 13
`define BIT_TX_RST 10
`define BIT_RX_RST 9
`define BIT_EMPTY_RSP 6
`define BIT_BURST_EN 5
`define BIT_SWAP 4
`define BIT_WAKE 2
`define BIT_PWR 1
`define BIT_NO_STALL 0
`define SPEED_HIGH 3'h0
`define SPEED_FULL 3'h1
`define DEF_LPM 1'h1
`define DEF_SUSP 1'h1
`define DEF_SWAP 1'h0
`define DEF_WAKE 1'h1
`define DEF_PWR 1'h1
`define RST_PULSE_CYC 2'h1
`define ZERO32 32'h00000000
`endif

// File: usb_cfg_default_sel.v
`timescale 1ns/1ps
`include "usb_cfg_map.vh"
// Picks one field's image default: EEPROM, then OTP, then fixed value
module usb_cfg_default_sel #(
  parameter OTP_OK = 1,
  parameter FIXED = 1'b1
) (
  input wire eeprom_present,
  input wire eeprom_bit,
  input wire otp_valid,
  input wire otp_bit,
  output wire value
);
  // Priority chain; power source passes OTP_OK=0 and skips OTP
  assign value = eeprom_present ? eeprom_bit :
                 ((OTP_OK != 0) && otp_valid) ? otp_bit : FIXED;
endmodule // usb_cfg_default_sel

// File: usb_device_config_register.v
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "usb_cfg_map.vh"
module usb_device_config_register (
  // Clock and reset
  input wire I_MCLK,
  input wire I_RST_N,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [11:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // Image sources (EEPROM flags and OTP flags)
  input wire i_eeprom_present,
  input wire i_otp_valid,
  input wire i_image_load,
  input wire i_eeprom_flag_lpm,
  input wire i_eeprom_flag_suspend,
  input wire i_eeprom_flag_pin_swap,
  input wire i_eeprom_flag_wake,
  input wire i_eeprom_flag_power_source,
  input wire i_otp_flag_lpm,
  input wire i_otp_flag_suspend,
  input wire i_otp_flag_pin_swap,
  input wire i_otp_flag_wake,
  // Reset events from the USB side
  input wire i_usb_reset,
  input wire i_lite_reset_cmd,
  // Core status inputs
  input wire i_suspend_cond,
  input wire i_rx_fifo_empty,
  input wire i_bulk_in_token,
  input wire i_sync_loss,
  input wire i_host_wake_enable,
  // Control outputs
  output reg O_SUSPEND_N,
  output reg O_LPM_ENABLE,
  output reg [2:0] O_CONNECT_SPEED,
  output reg O_BULK_IN_TX_RST,
  output reg O_BULK_OUT_RX_RST,
  output reg O_IN_NAK,
  output reg O_IN_ZLP,
  output reg O_BURST_LIMIT_EN,
  output reg O_PIN_SWAP,
  output reg O_REMOTE_WAKE_OK,
  output reg O_SELF_POWERED,
  output reg O_BULK_OUT_STALL
);
  // Port directions on wishbone named lower case per bus convention
  // Image defaults from the selector
  wire def_lpm;
  wire def_susp;
  wire def_swap;
  wire def_wake;
  wire def_pwr;
  // Field registers
  reg lpm_reg;
  reg susp_reg;
  reg [2:0] speed_reg;
  reg tx_rst_reg;
  reg rx_rst_reg;
  reg empty_rsp_reg;
  reg burst_en_reg;
  reg swap_reg;
  reg wake_reg;
  reg pwr_reg;
  reg no_stall_reg;
  // Latched image values, restored on USB or lite reset
  reg [4:0] image_reg;
  // Bus decode
  wire hit = i_wb_adr == `ADDR_USB_CONFIG_0;
  wire req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wr = req & i_wb_we & hit;
  wire restore = i_usb_reset | i_lite_reset_cmd;
  // Register read image, reserved bits zero [RULE_18]
  wire [31:0] rd_val = {1'b0, lpm_reg, susp_reg, 13'h0000, speed_reg, 2'h0,
    tx_rst_reg, rx_rst_reg, 2'h0, empty_rsp_reg, burst_en_reg, swap_reg,
    1'b0, wake_reg, pwr_reg, no_stall_reg};

  // Per-field default selection [RULE_13] [RULE_14] [RULE_15] [RULE_16]
  usb_cfg_default_sel #(.OTP_OK(1), .FIXED(`DEF_LPM)) u_lpm (
    .eeprom_present(i_eeprom_present), .eeprom_bit(i_eeprom_flag_lpm),
    .otp_valid(i_otp_valid), .otp_bit(i_otp_flag_lpm), .value(def_lpm));
  usb_cfg_default_sel #(.OTP_OK(1), .FIXED(`DEF_SUSP)) u_susp (
    .eeprom_present(i_eeprom_present), .eeprom_bit(i_eeprom_flag_suspend),
    .otp_valid(i_otp_valid), .otp_bit(i_otp_flag_suspend), .value(def_susp));
  usb_cfg_default_sel #(.OTP_OK(1), .FIXED(`DEF_SWAP)) u_swap (
    .eeprom_present(i_eeprom_present), .eeprom_bit(i_eeprom_flag_pin_swap),
    .otp_valid(i_otp_valid), .otp_bit(i_otp_flag_pin_swap), .value(def_swap));
  usb_cfg_default_sel #(.OTP_OK(1), .FIXED(`DEF_WAKE)) u_wake (
    .eeprom_present(i_eeprom_present), .eeprom_bit(i_eeprom_flag_wake),
    .otp_valid(i_otp_valid), .otp_bit(i_otp_flag_wake), .value(def_wake));
  usb_cfg_default_sel #(.OTP_OK(0), .FIXED(`DEF_PWR)) u_pwr (
    .eeprom_present(i_eeprom_present), .eeprom_bit(i_eeprom_flag_power_source),
    .otp_valid(i_otp_valid), .otp_bit(1'b0), .value(def_pwr));

  // Image capture: loader pulse latches the resolved defaults
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      // Fixed defaults until the first load
      image_reg <= {`DEF_LPM, `DEF_SUSP, `DEF_SWAP, `DEF_WAKE, `DEF_PWR};
    end else if (i_image_load) begin
      image_reg <= {def_lpm, def_susp, def_swap, def_wake, def_pwr};
    end
  end

  // Field registers with restore, write and self clear
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lpm_reg <= `DEF_LPM;
      susp_reg <= `DEF_SUSP;
      speed_reg <= `SPEED_HIGH; // [RULE_03]
      tx_rst_reg <= 1'b0;
      rx_rst_reg <= 1'b0;
      empty_rsp_reg <= 1'b0;
      burst_en_reg <= 1'b0;
      swap_reg <= `DEF_SWAP;
      wake_reg <= `DEF_WAKE;
      pwr_reg <= `DEF_PWR;
      no_stall_reg <= 1'b0;
    end else begin
      // Self-clearing bits drop after one applied cycle [RULE_19]
      tx_rst_reg <= 1'b0;
      rx_rst_reg <= 1'b0;
      if (i_image_load) begin
        // Fresh image overrides current values
        lpm_reg <= def_lpm;
        susp_reg <= def_susp;
        swap_reg <= def_swap;
        wake_reg <= def_wake;
        pwr_reg <= def_pwr;
      end else if (restore) begin
        // Restore protected fields from the last image [RULE_17] [RULE_12]
        lpm_reg <= image_reg[4];
        susp_reg <= image_reg[3];
        swap_reg <= image_reg[2];
        wake_reg <= image_reg[1];
        pwr_reg <= image_reg[0];
        speed_reg <= `SPEED_HIGH;
      end else if (wr) begin
        // Byte lanes; swap bit is read only [RULE_08]
        if (i_wb_sel[3]) begin
          lpm_reg <= i_wb_dat[`BIT_LPM]; // [RULE_01]
          susp_reg <= i_wb_dat[`BIT_SUSP]; // [RULE_02]
        end
        if (i_wb_sel[1]) begin
          speed_reg <= i_wb_dat[`SPD_HI:`SPD_LO]; // [RULE_03]
          tx_rst_reg <= i_wb_dat[`BIT_TX_RST]; // [RULE_04]
          rx_rst_reg <= i_wb_dat[`BIT_RX_RST]; // [RULE_05]
        end
        if (i_wb_sel[0]) begin
          empty_rsp_reg <= i_wb_dat[`BIT_EMPTY_RSP]; // [RULE_06]
          burst_en_reg <= i_wb_dat[`BIT_BURST_EN]; // [RULE_07]
          wake_reg <= i_wb_dat[`BIT_WAKE]; // [RULE_09]
          pwr_reg <= i_wb_dat[`BIT_PWR]; // [RULE_10]
          no_stall_reg <= i_wb_dat[`BIT_NO_STALL]; // [RULE_11]
        end
      end
    end
  end

  // Wishbone answer: ack one cycle after request, any address
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `ZERO32;
    end else begin
      o_wb_ack <= req;
      // Unmapped addresses read zero
      if (req && !i_wb_we) begin
        o_wb_dat <= hit ? rd_val : `ZERO32;
      end
    end
  end

  // Registered control outputs to the core
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SUSPEND_N <= 1'b1;
      O_LPM_ENABLE <= 1'b0;
      O_CONNECT_SPEED <= `SPEED_HIGH;
      O_BULK_IN_TX_RST <= 1'b0;
      O_BULK_OUT_RX_RST <= 1'b0;
      O_IN_NAK <= 1'b0;
      O_IN_ZLP <= 1'b0;
      O_BURST_LIMIT_EN <= 1'b0;
      O_PIN_SWAP <= 1'b0;
      O_REMOTE_WAKE_OK <= 1'b0;
      O_SELF_POWERED <= 1'b0;
      O_BULK_OUT_STALL <= 1'b0;
    end else begin
      O_SUSPEND_N <= ~(susp_reg & i_suspend_cond); // [RULE_02]
      O_LPM_ENABLE <= lpm_reg; // [RULE_01]
      O_CONNECT_SPEED <= speed_reg; // [RULE_03]
      O_BULK_IN_TX_RST <= tx_rst_reg; // [RULE_04]
      O_BULK_OUT_RX_RST <= rx_rst_reg; // [RULE_05]
      // Empty FIFO answer on an IN token [RULE_06]
      O_IN_NAK <= i_bulk_in_token & i_rx_fifo_empty & empty_rsp_reg;
      O_IN_ZLP <= i_bulk_in_token & i_rx_fifo_empty & ~empty_rsp_reg;
      O_BURST_LIMIT_EN <= burst_en_reg; // [RULE_07]
      O_PIN_SWAP <= swap_reg; // [RULE_08]
      O_REMOTE_WAKE_OK <= wake_reg & i_host_wake_enable; // [RULE_09]
      O_SELF_POWERED <= pwr_reg; // [RULE_10]
      // Sticky stall until receiver reset; a fresh loss beats the clear [RULE_11]
      if (i_sync_loss && !no_stall_reg)
        O_BULK_OUT_STALL <= 1'h1;
      else if (rx_rst_reg)
        O_BULK_OUT_STALL <= 1'h0;
    end
  end
endmodule // usb_device_config_register

// File: usb_cfg_props.sv
`timescale 1ns/1ps
// Watches bus answers and control outputs of the config register
module usb_cfg_props (
  // Clock and reset
  input wire I_MCLK,
  input wire I_RST_N,
  // Inputs of interest
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_usb_reset,
  input wire i_suspend_cond,
  input wire i_rx_fifo_empty,
  input wire i_bulk_in_token,
  input wire i_sync_loss,
  input wire i_host_wake_enable,
  // Outputs watched
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  input wire O_SUSPEND_N,
  input wire [2:0] O_CONNECT_SPEED,
  input wire O_BULK_IN_TX_RST,
  input wire O_IN_NAK,
  input wire O_IN_ZLP,
  input wire O_REMOTE_WAKE_OK,
  input wire O_BULK_OUT_STALL
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  AST_WB_ACK: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered next cycle");
  AST_RESV_ZERO: assert property (o_wb_ack |-> (o_wb_dat & 32'h9FFF1988) == 32'h0)
    else $error("reserved bits read nonzero");
  AST_IN_RSP: assert property (O_IN_NAK || O_IN_ZLP |-> $past(i_bulk_in_token && i_rx_fifo_empty))
    else $error("empty response without token on empty fifo");
  AST_WAKE: assert property (O_REMOTE_WAKE_OK |-> $past(i_host_wake_enable))
    else $error("remote wake allowed without host enable");
  AST_SUSP: assert property (!O_SUSPEND_N |-> $past(i_suspend_cond))
    else $error("suspend signalled without condition");
  AST_TX_PULSE: assert property (O_BULK_IN_TX_RST |=> !O_BULK_IN_TX_RST)
    else $error("transmitter reset longer than one cycle");
  AST_STALL: assert property ($rose(O_BULK_OUT_STALL) |-> $past(i_sync_loss) || $past(i_sync_loss, 2))
    else $error("stall raised without sync loss");
  AST_SPD_RESTORE: assert property (i_usb_reset |-> ##2 O_CONNECT_SPEED == 3'h0)
    else $error("speed not restored after usb reset");
endmodule // usb_cfg_props
bind usb_device_config_register usb_cfg_props u_props (
  .I_MCLK(I_MCLK),
  .I_RST_N(I_RST_N),
  .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb),
  .i_usb_reset(i_usb_reset),
  .i_suspend_cond(i_suspend_cond),
  .i_rx_fifo_empty(i_rx_fifo_empty),
  .i_bulk_in_token(i_bulk_in_token),
  .i_sync_loss(i_sync_loss),
  .i_host_wake_enable(i_host_wake_enable),
  .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack),
  .O_SUSPEND_N(O_SUSPEND_N),
  .O_CONNECT_SPEED(O_CONNECT_SPEED),
  .O_BULK_IN_TX_RST(O_BULK_IN_TX_RST),
  .O_IN_NAK(O_IN_NAK),
  .O_IN_ZLP(O_IN_ZLP),
  .O_REMOTE_WAKE_OK(O_REMOTE_WAKE_OK),
  .O_BULK_OUT_STALL(O_BULK_OUT_STALL)
);

// File: usb_host_model.sv
`timescale 1ns/1ps
// Far side: host tokens and line events, one cycle per call
module usb_host_model (
  // Clock
  input wire i_clk,
  // Events toward the device
  output logic o_token,
  output logic o_empty,
  output logic o_sync_loss,
  output logic o_susp,
  output logic o_wake
);
  // Drive one event pattern for one clock: token, empty, loss, suspend, wake
  task automatic drive(input logic [4:0] v);
    o_token <= v[4];
    o_empty <= v[3];
    o_sync_loss <= v[2];
    o_susp <= v[1];
    o_wake <= v[0];
    @(posedge i_clk);
  endtask
endmodule // usb_host_model

// File: usb_device_config_register_tb.sv
`timescale 1ns/1ps
// Register access, image loads and host event sequences
module usb_device_config_register_tb;
  logic I_MCLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0] sel = 4'h0;
  logic [10:0] img = 11'h000; // Presence, validity, eeprom and otp flags
  logic [2:0] ctl = 3'h0; // Image load, usb reset, lite reset
  wire [31:0] o_dat;
  wire o_ack, tok, emp, sloss, susp, wake, susp_n, nak, zlp, stall, wok;
  wire txr, rxr; // Transmitter and receiver reset pulses
  int n_txp = 0, n_rxp = 0; // Clock edges at which each pulse was seen high
  wire [6:0] outs; // Lpm, speed, burst, swap, power
  int n_mismatch = 0, tests_run = 0;
  always #10 I_MCLK = ~I_MCLK;
  usb_host_model host (.i_clk(I_MCLK), .o_token(tok), .o_empty(emp), .o_sync_loss(sloss),
    .o_susp(susp), .o_wake(wake));
  usb_device_config_register dut (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(o_dat), .o_wb_ack(o_ack), .i_eeprom_present(img[10]), .i_otp_valid(img[9]),
    .i_image_load(ctl[2]), .i_eeprom_flag_lpm(img[8]), .i_eeprom_flag_suspend(img[7]),
    .i_eeprom_flag_pin_swap(img[6]), .i_eeprom_flag_wake(img[5]),
    .i_eeprom_flag_power_source(img[4]), .i_otp_flag_lpm(img[3]), .i_otp_flag_suspend(img[2]),
    .i_otp_flag_pin_swap(img[1]), .i_otp_flag_wake(img[0]), .i_usb_reset(ctl[1]),
    .i_lite_reset_cmd(ctl[0]), .i_suspend_cond(susp), .i_rx_fifo_empty(emp),
    .i_bulk_in_token(tok), .i_sync_loss(sloss), .i_host_wake_enable(wake),
    .O_SUSPEND_N(susp_n), .O_LPM_ENABLE(outs[6]), .O_CONNECT_SPEED(outs[5:3]),
    .O_BULK_IN_TX_RST(txr), .O_BULK_OUT_RX_RST(rxr), .O_IN_NAK(nak), .O_IN_ZLP(zlp),
    .O_BURST_LIMIT_EN(outs[2]), .O_PIN_SWAP(outs[1]), .O_REMOTE_WAKE_OK(wok),
    .O_SELF_POWERED(outs[0]), .O_BULK_OUT_STALL(stall));
  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // Count reset pulses; one write must give exactly one high edge
  always @(posedge I_MCLK) begin
    if (txr === 1'b1) n_txp <= n_txp + 1;
    if (rxr === 1'b1) n_rxp <= n_rxp + 1;
  end
  // One classic bus cycle, held until ack; the watchdog ends a hang
  task automatic wb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge I_MCLK);
    end while (o_ack !== 1'b1);
    rdat = o_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge I_MCLK);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk("read", e, rdat);
  endtask
  // Pulse load or reset events for one clock
  task automatic evt(input logic [2:0] c);
    ctl <= c;
    @(posedge I_MCLK);
    ctl <= 3'h0;
    repeat (2) @(posedge I_MCLK);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    #100us;
    n_mismatch++;
    print_verdict();
  end
  // Main sequence; host patterns stand two clocks so outputs are settled when read
  initial begin
    host.drive(5'h00);
    repeat (2) @(posedge I_MCLK);
    I_RST_N <= 1'b1;
    @(posedge I_MCLK);
    rd(12'h080, 32'h60000006);
    wb(1'b1, 12'h080, 32'hFFFFFFFF, 4'hF);
    rd(12'h080, 32'h6000E067);
    chk("outs", 32'h7D, {25'h0, outs});
    chk("tx_pulse", 32'h1, n_txp);
    chk("rx_pulse", 32'h1, n_rxp);
    host.drive(5'h18);
    host.drive(5'h18);
    chk("in_rsp", 32'h2, {30'h0, nak, zlp});
    host.drive(5'h04);
    host.drive(5'h04);
    chk("stall", 32'h0, {31'h0, stall});
    host.drive(5'h00);
    wb(1'b1, 12'h080, 32'h0, 4'h1);
    rd(12'h080, 32'h6000E000);
    host.drive(5'h18);
    host.drive(5'h18);
    chk("in_rsp", 32'h1, {30'h0, nak, zlp});
    host.drive(5'h04);
    host.drive(5'h04);
    chk("stall", 32'h1, {31'h0, stall});
    host.drive(5'h00);
    wb(1'b1, 12'h080, 32'h200, 4'h2);
    chk("stall", 32'h0, {31'h0, stall});
    rd(12'h080, 32'h60000000);
    chk("rx_pulse", 32'h2, n_rxp);
    chk("tx_pulse", 32'h1, n_txp);
    rd(12'h084, 32'h0);
    evt(3'h2);
    rd(12'h080, 32'h60000006);
    host.drive(5'h03);
    host.drive(5'h03);
    chk("susp_wake", 32'h1, {30'h0, susp_n, wok});
    wb(1'b1, 12'h080, 32'h0, 4'hF);
    host.drive(5'h03);
    host.drive(5'h03);
    chk("susp_wake", 32'h2, {30'h0, susp_n, wok});
    host.drive(5'h00);
    img <= 11'h44F;
    evt(3'h4);
    rd(12'h080, 32'h00000010);
    chk("outs", 32'h02, {25'h0, outs});
    wb(1'b1, 12'h080, 32'hFFFFFFFF, 4'hF);
    evt(3'h1);
    rd(12'h080, 32'h00000071);
    chk("tx_pulse", 32'h2, n_txp);
    wb(1'b1, 12'h080, 32'h0, 4'hF);
    img <= 11'h3BA;
    evt(3'h4);
    rd(12'h080, 32'h40000012);
    img <= 11'h000;
    evt(3'h4);
    rd(12'h080, 32'h60000006);
    print_verdict();
  end
endmodule // usb_device_config_register_tb
